// [rtl/guard_pkg.sv]
// constants, register map and types for the overtravel torque and range guard
// assumes one 100 MHz clock and a plain word-wide register port
package guard_pkg;
	// clock and timing
	localparam int unsigned CLK_HZ = 100_000_000;
	localparam int unsigned STOP_TORQUE_DELAY_MS = 100;
	localparam int unsigned STOP_TORQUE_DELAY_CYCLES = STOP_TORQUE_DELAY_MS * (CLK_HZ / 1000);

	// register offsets (byte addresses, one word each)
	localparam logic [7:0] ADDR_STOP_TORQUE_LIMIT = 8'h00;
	localparam logic [7:0] ADDR_PROHIBIT_TORQUE_SELECT = 8'h04;
	localparam logic [7:0] ADDR_FORWARD_RANGE_PULSES = 8'h08;
	localparam logic [7:0] ADDR_FORWARD_RANGE_TURNS = 8'h0c;
	localparam logic [7:0] ADDR_REVERSE_RANGE_PULSES = 8'h10;
	localparam logic [7:0] ADDR_REVERSE_RANGE_TURNS = 8'h14;
	localparam logic [7:0] ADDR_SOFT_OVERTRAVEL_MODE = 8'h18;
	localparam logic [7:0] ADDR_EVENT_STATUS = 8'h20;
	localparam logic [7:0] ADDR_EVENT_MASK = 8'h24;
	localparam logic [7:0] ADDR_LIVE_STATE = 8'h28;

	// reset values
	localparam logic [15:0] RST_STOP_TORQUE_LIMIT = 16'h0064;
	localparam logic [15:0] RST_PROHIBIT_TORQUE_SELECT = 16'h0001;
	localparam logic [31:0] RST_FORWARD_RANGE_PULSES = 32'h0000_0000;
	localparam logic [15:0] RST_FORWARD_RANGE_TURNS = 16'h03e8;
	localparam logic [31:0] RST_REVERSE_RANGE_PULSES = 32'h0000_0000;
	localparam logic [15:0] RST_REVERSE_RANGE_TURNS = 16'h03e8;
	localparam logic [15:0] RST_SOFT_OVERTRAVEL_MODE = 16'h0001;
	localparam logic [2:0] RST_EVENT_MASK = 3'h0;

	// stop torque bounds, percent of rated torque
	localparam logic [15:0] STOP_TORQUE_MIN = 16'h0001;
	localparam logic [15:0] STOP_TORQUE_MAX = 16'h012c;
	localparam logic [15:0] TORQUE_ZERO = 16'h0000;

	// soft overtravel mode codes
	localparam logic [15:0] SOFT_MODE_OFF = 16'h0000;
	localparam logic [15:0] SOFT_MODE_ALARM = 16'h0001;
	localparam logic [15:0] SOFT_MODE_STOP = 16'h0002;

	// event status / mask bit positions
	localparam int EV_ALARM = 0;
	localparam int EV_SOFT_STOP = 1;
	localparam int EV_PROHIBIT = 2;
	localparam int EV_WIDTH = 3;

	// live state bit positions
	localparam int LS_FWD_EXCEED = 0;
	localparam int LS_REV_EXCEED = 1;
	localparam int LS_DELAY_PENDING = 2;
	localparam int LS_FWD_PROHIBIT = 3;
	localparam int LS_REV_PROHIBIT = 4;
	localparam int LS_ESTOP = 5;

	// combined position width: sign + turns + pulses
	localparam int POS_WIDTH = 49;

	typedef enum logic {
		DELAY_IDLE,
		DELAY_WAIT
	} delay_state_t;
endpackage : guard_pkg

// [rtl/range_compare.sv]
// one side of the travel range check: position from home against a limit
// assumes position and limit are stable combined turn:pulse values
`timescale 1ns/1ps
`default_nettype none
module range_compare #(
	parameter bit REVERSE = 1'b0
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic reset_n,
	// check enable, position from home, limit magnitude
	input wire logic enable,
	input wire logic signed [guard_pkg::POS_WIDTH-1:0] rel_pos,
	input wire logic signed [guard_pkg::POS_WIDTH-1:0] limit,
	// travel beyond the limit
	output logic exceed
);
	import guard_pkg::*;

	logic signed [POS_WIDTH-1:0] travel;
	logic exceed_next;

	// reverse travel is measured as a positive distance below home
	always_comb begin
		travel = REVERSE ? -rel_pos : rel_pos;
		exceed_next = enable && (travel > limit);
	end

	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			exceed <= 1'b0;
		end else begin
			exceed <= exceed_next;
		end
	end
endmodule : range_compare
`default_nettype wire

// [rtl/overtravel_torque_and_range_guard.sv]
// overtravel torque limiting and software travel range guard
// assumes synchronous inputs on ref_clk and a one-cycle register port
//
// How it works
// - prohibit or estop caps torque at setting
// - new stop torque applies 100 ms later
// - torque mode running uses prohibit torque select
// - select 0 uses stop torque, 1 zero
// - position outside range trips overtravel alarm
// - range measured from home, free between limits
// - forward limit is pulses plus turns
// - reverse limit is separate pulses plus turns
// - mode 0 off, 1 alarm, 2 stop
// - prohibit zeros speed only in blocked direction
//
// Chosen here: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module overtravel_torque_and_range_guard #(
	parameter int unsigned STOP_TORQUE_DELAY = guard_pkg::STOP_TORQUE_DELAY_CYCLES
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic reset_n,
	// register port
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	// prohibit and stop inputs
	input wire logic forward_prohibit_input,
	input wire logic reverse_prohibit_input,
	input wire logic estop_input,
	// drive state
	input wire logic torque_mode,
	input wire logic motor_running,
	// encoder multiturn position and home capture
	input wire logic home_set,
	input wire logic [15:0] pos_turns,
	input wire logic [31:0] pos_pulses,
	// torque and speed limiting
	output logic [15:0] torque_limit,
	output logic torque_limit_active,
	output logic speed_zero_fwd,
	output logic speed_zero_rev,
	// alarm and interrupt
	output logic soft_overtravel_alarm,
	output logic irq
);
	import guard_pkg::*;

	// software registers
	logic [15:0] stop_torque_limit_reg, stop_torque_limit_next;
	logic [15:0] prohibit_torque_select_reg, prohibit_torque_select_next;
	logic [31:0] forward_range_pulses_reg, forward_range_pulses_next;
	logic [15:0] forward_range_turns_reg, forward_range_turns_next;
	logic [31:0] reverse_range_pulses_reg, reverse_range_pulses_next;
	logic [15:0] reverse_range_turns_reg, reverse_range_turns_next;
	logic [15:0] soft_overtravel_mode_reg, soft_overtravel_mode_next;
	logic [EV_WIDTH-1:0] event_mask_reg, event_mask_next;
	logic [31:0] rdata_reg, rdata_next;
	logic wr_stop_torque;
	logic [EV_WIDTH-1:0] event_status_reg, event_status_next, event_set, event_clear;
	logic [5:0] live_state;

	// write decode and registered read-back
	always_comb begin
		wr_stop_torque = reg_wr && (reg_addr == ADDR_STOP_TORQUE_LIMIT);
		stop_torque_limit_next = wr_stop_torque ? reg_wdata[15:0] : stop_torque_limit_reg;
		prohibit_torque_select_next = prohibit_torque_select_reg;
		forward_range_pulses_next = forward_range_pulses_reg;
		forward_range_turns_next = forward_range_turns_reg;
		reverse_range_pulses_next = reverse_range_pulses_reg;
		reverse_range_turns_next = reverse_range_turns_reg;
		soft_overtravel_mode_next = soft_overtravel_mode_reg;
		event_mask_next = event_mask_reg;
		if (reg_wr) begin
			unique case (reg_addr)
				ADDR_PROHIBIT_TORQUE_SELECT: prohibit_torque_select_next = reg_wdata[15:0];
				ADDR_FORWARD_RANGE_PULSES: forward_range_pulses_next = reg_wdata;
				ADDR_FORWARD_RANGE_TURNS: forward_range_turns_next = reg_wdata[15:0];
				ADDR_REVERSE_RANGE_PULSES: reverse_range_pulses_next = reg_wdata;
				ADDR_REVERSE_RANGE_TURNS: reverse_range_turns_next = reg_wdata[15:0];
				ADDR_SOFT_OVERTRAVEL_MODE: soft_overtravel_mode_next = reg_wdata[15:0];
				ADDR_EVENT_MASK: event_mask_next = reg_wdata[EV_WIDTH-1:0];
				default: ;
			endcase
		end
		rdata_next = 32'h0000_0000;
		if (reg_rd) begin
			unique case (reg_addr)
				ADDR_STOP_TORQUE_LIMIT: rdata_next = {16'h0000, stop_torque_limit_reg};
				ADDR_PROHIBIT_TORQUE_SELECT: rdata_next = {16'h0000, prohibit_torque_select_reg};
				ADDR_FORWARD_RANGE_PULSES: rdata_next = forward_range_pulses_reg;
				ADDR_FORWARD_RANGE_TURNS: rdata_next = {16'h0000, forward_range_turns_reg};
				ADDR_REVERSE_RANGE_PULSES: rdata_next = reverse_range_pulses_reg;
				ADDR_REVERSE_RANGE_TURNS: rdata_next = {16'h0000, reverse_range_turns_reg};
				ADDR_SOFT_OVERTRAVEL_MODE: rdata_next = {16'h0000, soft_overtravel_mode_reg};
				ADDR_EVENT_STATUS: rdata_next = {29'h0000_0000, event_status_reg};
				ADDR_EVENT_MASK: rdata_next = {29'h0000_0000, event_mask_reg};
				ADDR_LIVE_STATE: rdata_next = {26'h000_0000, live_state};
				default: rdata_next = 32'h0000_0000; // unmapped reads as zero
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			stop_torque_limit_reg <= RST_STOP_TORQUE_LIMIT;
			prohibit_torque_select_reg <= RST_PROHIBIT_TORQUE_SELECT;
			forward_range_pulses_reg <= RST_FORWARD_RANGE_PULSES;
			forward_range_turns_reg <= RST_FORWARD_RANGE_TURNS;
			reverse_range_pulses_reg <= RST_REVERSE_RANGE_PULSES;
			reverse_range_turns_reg <= RST_REVERSE_RANGE_TURNS;
			soft_overtravel_mode_reg <= RST_SOFT_OVERTRAVEL_MODE;
			event_mask_reg <= RST_EVENT_MASK;
			rdata_reg <= 32'h0000_0000;
		end else begin
			stop_torque_limit_reg <= stop_torque_limit_next;
			prohibit_torque_select_reg <= prohibit_torque_select_next;
			forward_range_pulses_reg <= forward_range_pulses_next;
			forward_range_turns_reg <= forward_range_turns_next;
			reverse_range_pulses_reg <= reverse_range_pulses_next;
			reverse_range_turns_reg <= reverse_range_turns_next;
			soft_overtravel_mode_reg <= soft_overtravel_mode_next;
			event_mask_reg <= event_mask_next;
			rdata_reg <= rdata_next;
		end
	end

	// delayed stop torque: a rewrite during the wait restarts it
	delay_state_t delay_state_reg, delay_state_next;
	logic [31:0] delay_count_reg, delay_count_next;
	logic [15:0] pending_torque_reg, pending_torque_next;
	logic [15:0] eff_torque_reg, eff_torque_next;

	always_comb begin
		delay_state_next = delay_state_reg;
		delay_count_next = delay_count_reg;
		pending_torque_next = pending_torque_reg;
		eff_torque_next = eff_torque_reg;
		if (wr_stop_torque) begin
			delay_state_next = DELAY_WAIT;
			delay_count_next = 32'h0000_0000;
			pending_torque_next = reg_wdata[15:0];
		end else begin
			unique case (delay_state_reg)
				DELAY_IDLE: ;
				DELAY_WAIT: begin
					if (delay_count_reg == STOP_TORQUE_DELAY - 1) begin
						delay_state_next = DELAY_IDLE;
						// out-of-range settings are held to the legal band
						if (pending_torque_reg < STOP_TORQUE_MIN) begin
							eff_torque_next = STOP_TORQUE_MIN;
						end else if (pending_torque_reg > STOP_TORQUE_MAX) begin
							eff_torque_next = STOP_TORQUE_MAX;
						end else begin
							eff_torque_next = pending_torque_reg;
						end
					end else begin
						delay_count_next = delay_count_reg + 32'h0000_0001;
					end
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			delay_state_reg <= DELAY_IDLE;
			delay_count_reg <= 32'h0000_0000;
			pending_torque_reg <= RST_STOP_TORQUE_LIMIT;
			eff_torque_reg <= RST_STOP_TORQUE_LIMIT;
		end else begin
			delay_state_reg <= delay_state_next;
			delay_count_reg <= delay_count_next;
			pending_torque_reg <= pending_torque_next;
			eff_torque_reg <= eff_torque_next;
		end
	end

	// home origin and position relative to it
	logic [47:0] home_reg, home_next;
	logic signed [POS_WIDTH-1:0] rel_pos, fwd_limit, rev_limit;
	logic fwd_exceed, rev_exceed, soft_enable;

	always_comb begin
		home_next = home_set ? {pos_turns, pos_pulses} : home_reg;
		// turns in the high part make a plain compare lexicographic
		rel_pos = $signed({pos_turns[15], pos_turns, pos_pulses}) - $signed({home_reg[47], home_reg});
		fwd_limit = $signed({1'b0, forward_range_turns_reg, forward_range_pulses_reg});
		rev_limit = $signed({1'b0, reverse_range_turns_reg, reverse_range_pulses_reg});
		soft_enable = (soft_overtravel_mode_reg == SOFT_MODE_ALARM) || (soft_overtravel_mode_reg == SOFT_MODE_STOP);
	end

	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			home_reg <= 48'h0000_0000_0000;
		end else begin
			home_reg <= home_next;
		end
	end

	range_compare #(.REVERSE(1'b0)) fwd_check (
		.ref_clk(ref_clk),
		.reset_n(reset_n),
		.enable(soft_enable),
		.rel_pos(rel_pos),
		.limit(fwd_limit),
		.exceed(fwd_exceed)
	);

	range_compare #(.REVERSE(1'b1)) rev_check (
		.ref_clk(ref_clk),
		.reset_n(reset_n),
		.enable(soft_enable),
		.rel_pos(rel_pos),
		.limit(rev_limit),
		.exceed(rev_exceed)
	);

	// torque limit, speed blocking, alarm and events
	logic [15:0] torque_limit_next;
	logic torque_limit_active_next, speed_zero_fwd_next, speed_zero_rev_next;
	logic alarm_next, irq_next, prohibit_any, prohibit_any_reg, soft_stop, soft_stop_reg;

	always_comb begin
		prohibit_any = forward_prohibit_input || reverse_prohibit_input || estop_input;
		soft_stop = (soft_overtravel_mode_reg == SOFT_MODE_STOP) && (fwd_exceed || rev_exceed);
		torque_limit_next = STOP_TORQUE_MAX;
		torque_limit_active_next = 1'b0;
		if (torque_mode && motor_running && (forward_prohibit_input || reverse_prohibit_input)) begin
			torque_limit_active_next = 1'b1;
			torque_limit_next = prohibit_torque_select_reg[0] ? TORQUE_ZERO : eff_torque_reg;
		end else if (prohibit_any) begin
			torque_limit_active_next = 1'b1;
			torque_limit_next = eff_torque_reg;
		end
		// mode 2 blocks the exceeded direction without alarming
		speed_zero_fwd_next = forward_prohibit_input || (soft_stop && fwd_exceed);
		speed_zero_rev_next = reverse_prohibit_input || (soft_stop && rev_exceed);
		event_set = '0;
		event_set[EV_ALARM] = (soft_overtravel_mode_reg == SOFT_MODE_ALARM) && (fwd_exceed || rev_exceed);
		event_set[EV_SOFT_STOP] = soft_stop && !soft_stop_reg;
		event_set[EV_PROHIBIT] = prohibit_any && !prohibit_any_reg;
		event_clear = (reg_wr && reg_addr == ADDR_EVENT_STATUS) ? reg_wdata[EV_WIDTH-1:0] : '0;
		// set wins over a clear in the same cycle
		event_status_next = (event_status_reg & ~event_clear) | event_set;
		irq_next = |(event_status_next & event_mask_next); // next values, so irq rises with the bit
		alarm_next = event_set[EV_ALARM] || (soft_overtravel_alarm && !event_clear[EV_ALARM]);
		live_state = '0;
		live_state[LS_FWD_EXCEED] = fwd_exceed;
		live_state[LS_REV_EXCEED] = rev_exceed;
		live_state[LS_DELAY_PENDING] = (delay_state_reg == DELAY_WAIT);
		live_state[LS_FWD_PROHIBIT] = forward_prohibit_input;
		live_state[LS_REV_PROHIBIT] = reverse_prohibit_input;
		live_state[LS_ESTOP] = estop_input;
	end

	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			torque_limit <= STOP_TORQUE_MAX;
			torque_limit_active <= 1'b0;
			speed_zero_fwd <= 1'b0;
			speed_zero_rev <= 1'b0;
			soft_overtravel_alarm <= 1'b0;
			event_status_reg <= '0;
			prohibit_any_reg <= 1'b0;
			soft_stop_reg <= 1'b0;
			irq <= 1'b0;
		end else begin
			torque_limit <= torque_limit_next;
			torque_limit_active <= torque_limit_active_next;
			speed_zero_fwd <= speed_zero_fwd_next;
			speed_zero_rev <= speed_zero_rev_next;
			soft_overtravel_alarm <= alarm_next;
			event_status_reg <= event_status_next;
			prohibit_any_reg <= prohibit_any;
			soft_stop_reg <= soft_stop;
			irq <= irq_next;
		end
	end

	assign reg_rdata = rdata_reg;

	// checks
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!reset_n);

	AST_STOP_TORQUE_CAP: assert property (prohibit_any && !torque_mode |=> torque_limit == $past(eff_torque_reg))
		else $error("stop torque not applied under prohibit");
	AST_DELAY_ONLY_AFTER_WAIT: assert property ($changed(eff_torque_reg) |-> $past(delay_state_reg) == DELAY_WAIT && $past(delay_count_reg) == STOP_TORQUE_DELAY - 1)
		else $error("stop torque changed before delay elapsed");
	AST_TORQUE_MODE_ZERO: assert property (torque_mode && motor_running && forward_prohibit_input && prohibit_torque_select_reg[0] |=> torque_limit == TORQUE_ZERO && torque_limit_active)
		else $error("torque mode prohibit did not force zero");
	AST_SELECT_ZERO_STOP: assert property (torque_mode && motor_running && reverse_prohibit_input && !prohibit_torque_select_reg[0] |=> torque_limit == $past(eff_torque_reg))
		else $error("select 0 did not use stop torque");
	AST_ALARM_TRIP: assert property (soft_overtravel_mode_reg == SOFT_MODE_ALARM && rev_exceed |=> soft_overtravel_alarm ##1 event_status_reg[EV_ALARM] || soft_overtravel_alarm)
		else $error("overtravel alarm not raised");
	AST_ALARM_ONLY_IN_ALARM_MODE: assert property ($rose(soft_overtravel_alarm) |-> $past(soft_overtravel_mode_reg) == SOFT_MODE_ALARM)
		else $error("alarm raised outside alarm mode");
	AST_FWD_EXCEED_CAUSE: assert property ($rose(fwd_exceed) |-> $past(rel_pos) > $past(fwd_limit))
		else $error("forward exceed without crossing limit");
	AST_FREE_INSIDE_RANGE: assert property (soft_enable && rel_pos <= fwd_limit && -rel_pos <= rev_limit |=> !fwd_exceed && !rev_exceed)
		else $error("exceed flagged inside range");
	AST_FWD_BLOCK: assert property (forward_prohibit_input |=> speed_zero_fwd)
		else $error("forward speed not blocked");
	AST_REV_FREE: assert property (forward_prohibit_input && !reverse_prohibit_input && !soft_stop |=> !speed_zero_rev)
		else $error("opposite direction wrongly blocked");
endmodule : overtravel_torque_and_range_guard
`default_nettype wire

// [testbench/encoder_switch_model.sv]
// behavioural encoder and limit switch stage facing the guard
// assumes the bench commands position and switch levels right after an edge
`timescale 1ns/1ps
`default_nettype none
module encoder_switch_model (
	// clock
	input wire logic ref_clk,
	// commanded levels from the bench
	input wire logic cmd_fwd,
	input wire logic cmd_rev,
	input wire logic cmd_estop,
	input wire logic [15:0] cmd_turns,
	input wire logic [31:0] cmd_pulses,
	// lines into the guard
	output logic forward_prohibit_input,
	output logic reverse_prohibit_input,
	output logic estop_input,
	output logic [15:0] pos_turns,
	output logic [31:0] pos_pulses
);
	// one edge of lag, like a real sampled switch and encoder front end
	always_ff @(posedge ref_clk) begin
		forward_prohibit_input <= cmd_fwd;
		reverse_prohibit_input <= cmd_rev;
		estop_input <= cmd_estop;
		pos_turns <= cmd_turns;
		pos_pulses <= cmd_pulses;
	end
endmodule : encoder_switch_model
`default_nettype wire

// [testbench/overtravel_torque_and_range_guard_tb_top.sv]
// self-checking bench for the overtravel torque and range guard
// assumes the stop torque delay is shortened through its parameter
`timescale 1ns/1ps
`default_nettype none
module overtravel_torque_and_range_guard_tb_top;
	import guard_pkg::*;
	localparam int unsigned DLY = 8;
	localparam logic signed [48:0] FWD_LIM = {1'b0, 16'h0002, 32'h0000_0100};
	localparam logic signed [48:0] REV_LIM = {1'b0, 16'h0001, 32'h0000_0000};
	logic ref_clk, reset_n, reg_wr, reg_rd, torque_mode, motor_running, home_set;
	logic cmd_fwd, cmd_rev, cmd_estop, fwd_p, rev_p, est_p;
	logic [7:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata, rdv, cmd_pulses, p_pulses;
	logic [15:0] cmd_turns, p_turns, torque_limit, nv, stq;
	logic torque_limit_active, speed_zero_fwd, speed_zero_rev, soft_overtravel_alarm, irq, exp_alarm;
	logic [1:0] ex;
	logic [15:0] modes [4] = '{16'h0001, 16'h0002, 16'h0000, 16'h0003};
	logic [15:0] pt [5] = '{16'h000c, 16'h000c, 16'h0009, 16'h0008, 16'h000a};
	logic [31:0] pp [5] = '{32'h100, 32'h101, 32'h0, 32'hffff_ffff, 32'h5};
	int failures = 0;
	int total_checks = 0;
	int unsigned seed_dummy;

	encoder_switch_model partner (.ref_clk(ref_clk), .cmd_fwd(cmd_fwd), .cmd_rev(cmd_rev), .cmd_estop(cmd_estop),
		.cmd_turns(cmd_turns), .cmd_pulses(cmd_pulses), .forward_prohibit_input(fwd_p),
		.reverse_prohibit_input(rev_p), .estop_input(est_p), .pos_turns(p_turns), .pos_pulses(p_pulses));

	overtravel_torque_and_range_guard #(.STOP_TORQUE_DELAY(DLY)) uut (.ref_clk(ref_clk), .reset_n(reset_n),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.forward_prohibit_input(fwd_p), .reverse_prohibit_input(rev_p), .estop_input(est_p),
		.torque_mode(torque_mode), .motor_running(motor_running), .home_set(home_set), .pos_turns(p_turns),
		.pos_pulses(p_pulses), .torque_limit(torque_limit), .torque_limit_active(torque_limit_active),
		.speed_zero_fwd(speed_zero_fwd), .speed_zero_rev(speed_zero_rev),
		.soft_overtravel_alarm(soft_overtravel_alarm), .irq(irq));

	// expected effective stop torque after clamping
	function automatic logic [15:0] clamp_t(input logic [15:0] v);
		return (v < 16'h0001) ? 16'h0001 : ((v > 16'h012c) ? 16'h012c : v);
	endfunction : clamp_t

	// expected torque limit from the priority of the inputs
	function automatic logic [15:0] exp_torque(input logic f, r, e, tm, run, sel, input logic [15:0] s);
		if (tm && run && (f || r)) return sel ? 16'h0000 : s;
		if (f || r || e) return s;
		return 16'h012c;
	endfunction : exp_torque

	// {forward, reverse} exceed for a position against a home at turn ten
	function automatic logic [1:0] exp_exceed(input logic [15:0] t, input logic [31:0] p);
		logic signed [48:0] rel;
		rel = $signed({1'b0, t, p}) - $signed({1'b0, 16'h000a, 32'h0});
		return {rel > FWD_LIM, -rel > REV_LIM};
	endfunction : exp_exceed

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			failures++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	// tasks start on an edge so a strobe is never assigned twice in one step
	task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask : reg_write

	task automatic chk_reg(input logic [7:0] a, input logic [31:0] exp);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1;
		rdv = reg_rdata;
		chk(rdv, exp);
	endtask : chk_reg

	// covers partner lag plus two registered stages
	task automatic settle;
		repeat (5) @(posedge ref_clk);
		#1;
	endtask : settle

	task automatic close_out;
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : close_out

	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end

	// cut a hang short well past the expected run length
	initial begin
		repeat (20000) @(posedge ref_clk);
		failures++;
		close_out();
	end

	initial begin
		reset_n = 1'b0;
		{reg_wr, reg_rd, torque_mode, motor_running, home_set, cmd_fwd, cmd_rev, cmd_estop} = 8'h00;
		reg_addr = 8'h00;
		reg_wdata = 32'h0;
		cmd_turns = 16'h0000;
		cmd_pulses = 32'h0;
		exp_alarm = 1'b0;
		seed_dummy = $urandom(32'h0187);
		repeat (2) @(posedge ref_clk);
		reset_n <= 1'b1;
		// register defaults, then an unmapped hole
		chk_reg(ADDR_STOP_TORQUE_LIMIT, 32'h64);
		chk_reg(ADDR_PROHIBIT_TORQUE_SELECT, 32'h1);
		chk_reg(ADDR_FORWARD_RANGE_PULSES, 32'h0);
		chk_reg(ADDR_FORWARD_RANGE_TURNS, 32'h3e8);
		chk_reg(ADDR_REVERSE_RANGE_PULSES, 32'h0);
		chk_reg(ADDR_REVERSE_RANGE_TURNS, 32'h3e8);
		chk_reg(ADDR_SOFT_OVERTRAVEL_MODE, 32'h1);
		chk_reg(8'h1c, 32'h0);
		// every combination of switches, mode and select
		for (int i = 0; i < 64; i++) begin
			reg_write(ADDR_PROHIBIT_TORQUE_SELECT, {31'h0, i[5]});
			@(posedge ref_clk);
			{cmd_fwd, cmd_rev, cmd_estop, torque_mode, motor_running} <= i[4:0];
			settle();
			chk({16'h0, torque_limit}, {16'h0, exp_torque(i[4], i[3], i[2], i[1], i[0], i[5], 16'h0064)});
			chk({31'h0, torque_limit_active}, {31'h0, |i[4:2]});
			chk({30'h0, speed_zero_fwd, speed_zero_rev}, {30'h0, i[4:3]});
		end
		// prohibit onset is sticky in status; unmask, then clear by one
		@(posedge ref_clk);
		{cmd_fwd, cmd_rev, cmd_estop, torque_mode, motor_running} <= 5'h00;
		chk_reg(ADDR_EVENT_STATUS, 32'h4);
		reg_write(ADDR_EVENT_MASK, 32'h4);
		settle();
		chk({31'h0, irq}, 32'h1);
		reg_write(ADDR_EVENT_STATUS, 32'h4);
		settle();
		chk({31'h0, irq}, 32'h0);
		// new stop torque reaches the limit only after the delay
		@(posedge ref_clk);
		cmd_estop <= 1'b1;
		settle();
		stq = 16'h0064;
		for (int k = 0; k < 6; k++) begin
			nv = (k == 0) ? 16'h0000 : ((k == 1) ? 16'h0190 : 16'(1 + $urandom_range(299)));
			reg_write(ADDR_STOP_TORQUE_LIMIT, {16'h0, nv});
			repeat (5) @(posedge ref_clk);
			#1;
			chk({16'h0, torque_limit}, {16'h0, stq});
			stq = clamp_t(nv);
			repeat (DLY - 1) @(posedge ref_clk);
			#1;
			chk({16'h0, torque_limit}, {16'h0, stq});
			chk_reg(ADDR_STOP_TORQUE_LIMIT, {16'h0, nv});
		end
		// estop level and idle delay show in live state
		chk_reg(ADDR_LIVE_STATE, 32'h20);
		chk_reg(ADDR_EVENT_MASK, 32'h4);
		// travel limits around a home at turn ten
		@(posedge ref_clk);
		cmd_estop <= 1'b0;
		cmd_turns <= 16'h000a;
		reg_write(ADDR_FORWARD_RANGE_TURNS, 32'h2);
		reg_write(ADDR_FORWARD_RANGE_PULSES, 32'h100);
		reg_write(ADDR_REVERSE_RANGE_TURNS, 32'h1);
		reg_write(ADDR_EVENT_MASK, 32'h1);
		@(posedge ref_clk);
		home_set <= 1'b1;
		@(posedge ref_clk);
		home_set <= 1'b0;
		// limits were tightened before homing, so drop that stale trip
		reg_write(ADDR_EVENT_STATUS, 32'h7);
		// boundaries and one step past them, for every mode code
		for (int m = 0; m < 4; m++) begin
			reg_write(ADDR_SOFT_OVERTRAVEL_MODE, {16'h0, modes[m]});
			for (int n = 0; n < 5; n++) begin
				@(posedge ref_clk);
				cmd_turns <= pt[n];
				cmd_pulses <= pp[n];
				settle();
				ex = exp_exceed(pt[n], pp[n]);
				if (modes[m] == SOFT_MODE_ALARM && ex != 2'b00) exp_alarm = 1'b1;
				chk({31'h0, soft_overtravel_alarm}, {31'h0, exp_alarm});
				chk({31'h0, irq}, {31'h0, exp_alarm});
				chk({30'h0, speed_zero_fwd, speed_zero_rev}, (modes[m] == SOFT_MODE_STOP) ? {30'h0, ex} : 32'h0);
			end
			reg_write(ADDR_EVENT_STATUS, 32'h7);
			exp_alarm = 1'b0;
			settle();
			chk({31'h0, soft_overtravel_alarm}, 32'h0);
		end
		close_out();
	end
endmodule : overtravel_torque_and_range_guard_tb_top
`default_nettype wire
